// [hdl/pmc_pkg.sv]
package pmc_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W                = 3;
    localparam int unsigned DATA_W                = 8;
    localparam int unsigned EVT_W                 = 3;

    // Register offsets
    localparam logic [2:0]  OFS_DETECT_CTRL       = 3'h0;
    localparam logic [2:0]  OFS_WARN_STOP_CTRL    = 3'h1;
    localparam logic [2:0]  OFS_SYS_OPTIONS       = 3'h2;
    localparam logic [2:0]  OFS_EVT_STATUS        = 3'h3;
    localparam logic [2:0]  OFS_EVT_MASK          = 3'h4;

    // Detect control/status field positions
    localparam int unsigned DET_FLAG_BIT          = 7;
    localparam int unsigned DET_ACK_BIT           = 6;
    localparam int unsigned DET_IRQ_EN_BIT        = 5;
    localparam int unsigned DET_RST_EN_BIT        = 4;
    localparam int unsigned DET_STOP_EN_BIT       = 3;
    localparam int unsigned DET_MASTER_EN_BIT     = 2;
    localparam int unsigned DET_RSVD_BIT          = 1;
    localparam int unsigned DET_REFBUF_EN_BIT     = 0;

    // Warning / stop control/status field positions
    localparam int unsigned WRN_FLAG_BIT          = 7;
    localparam int unsigned WRN_ACK_BIT           = 6;
    localparam int unsigned WRN_DET_TRIP_BIT      = 5;
    localparam int unsigned WRN_WARN_TRIP_BIT     = 4;
    localparam int unsigned WRN_DS_FLAG_BIT       = 3;
    localparam int unsigned WRN_DS_ACK_BIT        = 2;
    localparam int unsigned WRN_DS_SEL_BIT        = 0;

    // System options field position
    localparam int unsigned OPT_WDOG_CLK_BIT      = 7;

    // Event status / mask field positions
    localparam int unsigned EVT_DETECT_BIT        = 0;
    localparam int unsigned EVT_WARN_BIT          = 1;
    localparam int unsigned EVT_DEEP_EXIT_BIT     = 2;

    // Values after reset
    localparam logic        RST_IRQ_EN            = 1'b0;
    localparam logic        RST_RST_EN            = 1'b1;
    localparam logic        RST_STOP_EN           = 1'b1;
    localparam logic        RST_MASTER_EN         = 1'b1;
    localparam logic        RST_REFBUF_EN         = 1'b0;
    localparam logic        RST_TRIP_SEL          = 1'b0;
    localparam logic        RST_DS_SEL            = 1'b0;
    localparam logic        RST_WDOG_CLK          = 1'b0;
    localparam logic [2:0]  RST_EVT_MASK          = 3'h0;
    localparam logic [7:0]  RST_RDATA             = 8'h00;

endpackage : pmc_pkg

// [hdl/pmc_top.sv]
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module pmc_top (
    // Clock and reset
    input  wire logic                      REF_CLK_IN,
    input  wire logic                      RST_N_IN,
    // Reset cause and power state, from same-clock system logic
    input  wire logic                      POR_CAUSE_IN,
    input  wire logic                      DEEP_STOP_WAKE_IN,
    input  wire logic                      STOP_MODE_IN,
    // Analog comparator levels, asynchronous
    input  wire logic                      UNDERVOLT_DETECT_IN,
    input  wire logic                      SUPPLY_WARNING_IN,
    // Register bus
    input  wire logic [pmc_pkg::ADDR_W-1:0] ADDR_IN,
    input  wire logic [pmc_pkg::DATA_W-1:0] WDATA_IN,
    input  wire logic                      WR_IN,
    input  wire logic                      RD_IN,
    output logic      [pmc_pkg::DATA_W-1:0] RDATA_OUT,
    // Control outputs
    output logic                           DETECT_TRIP_SEL_OUT,
    output logic                           WARN_TRIP_SEL_OUT,
    output logic                           REF_BUF_EN_OUT,
    output logic                           DEEP_STOP_SEL_OUT,
    output logic                           WDOG_CLK_SEL_OUT,
    output logic                           UNDERVOLT_ACTIVE_OUT,
    // Requests
    output logic                           UNDERVOLT_RESET_OUT,
    output logic                           UNDERVOLT_IRQ_OUT,
    output logic                           EVT_IRQ_OUT
);

    import pmc_pkg::*;

    // Synchronisers for the comparator levels
    logic              det_meta_r;
    logic              det_sync_r;
    logic              wrn_meta_r;
    logic              wrn_sync_r;

    // Register state
    logic              detect_flag_r;
    logic              detect_flag_nxt;
    logic              irq_en_r;
    logic              refbuf_en_r;
    logic              warn_flag_r;
    logic              warn_flag_nxt;
    logic              det_trip_r;
    logic              warn_trip_r;
    logic              ds_flag_r;
    logic              ds_flag_nxt;
    logic              first_cycle_r;
    logic [EVT_W-1:0]  evt_status_r;
    logic [EVT_W-1:0]  evt_status_nxt;
    logic [EVT_W-1:0]  evt_mask_r;
    logic              reset_req_r;
    logic [DATA_W-1:0] rdata_r;

    // Write-once bits
    logic              rst_en;
    logic              stop_en;
    logic              master_en;
    logic              ds_sel;
    logic              wdog_clk;

    // Address decode
    wire               sel_det   = (ADDR_IN == OFS_DETECT_CTRL);
    wire               sel_wrn   = (ADDR_IN == OFS_WARN_STOP_CTRL);
    wire               sel_opt   = (ADDR_IN == OFS_SYS_OPTIONS);
    wire               sel_evt   = (ADDR_IN == OFS_EVT_STATUS);
    wire               sel_msk   = (ADDR_IN == OFS_EVT_MASK);

    // Write strobes per register
    wire               wr_det    = WR_IN && sel_det;
    wire               wr_wrn    = WR_IN && sel_wrn;
    wire               wr_opt    = WR_IN && sel_opt;
    wire               wr_evt    = WR_IN && sel_evt;
    wire               wr_msk    = WR_IN && sel_msk;

    // Acknowledge strobes
    wire               det_ack   = wr_det && WDATA_IN[DET_ACK_BIT];
    wire               wrn_ack   = wr_wrn && WDATA_IN[WRN_ACK_BIT];
    wire               ds_ack    = wr_wrn && WDATA_IN[WRN_DS_ACK_BIT];

    // Detection is live when enabled and, in stop, only with stop enable
    wire               det_live  = master_en && (!STOP_MODE_IN || stop_en);
    wire               det_set   = det_live && det_sync_r;
    wire               wrn_set   = wrn_sync_r;
    wire               ds_set    = first_cycle_r && DEEP_STOP_WAKE_IN;

    // Hardware events for the sticky status register
    wire [EVT_W-1:0]   evt_hit;
    assign evt_hit[EVT_DETECT_BIT]    = det_set && !detect_flag_r;
    assign evt_hit[EVT_WARN_BIT]      = wrn_set && !warn_flag_r;
    assign evt_hit[EVT_DEEP_EXIT_BIT] = ds_set;

    // Flag next values: a set in the same cycle as an acknowledge wins, so no event is lost
    assign detect_flag_nxt = det_set ? 1'b1 :
                             det_ack ? 1'b0 :
                                       detect_flag_r;
    assign warn_flag_nxt   = wrn_set ? 1'b1 :
                             wrn_ack ? 1'b0 :
                                       warn_flag_r;
    assign ds_flag_nxt     = ds_set  ? 1'b1 :
                             ds_ack  ? 1'b0 :
                                       ds_flag_r;

    // Sticky event bits clear on written ones; a new event in the same cycle wins
    wire [EVT_W-1:0]   evt_clr = wr_evt ? WDATA_IN[EVT_W-1:0] : {EVT_W{1'b0}};
    assign evt_status_nxt  = evt_hit | (evt_status_r & ~evt_clr);

    // Read data assembly; write-only and reserved bits read zero
    wire [DATA_W-1:0]  rd_det;
    wire [DATA_W-1:0]  rd_wrn;
    wire [DATA_W-1:0]  rd_opt;
    assign rd_det = {detect_flag_r, 1'b0, irq_en_r, rst_en, stop_en, master_en, 1'b0, refbuf_en_r};
    assign rd_wrn = {warn_flag_r, 1'b0, det_trip_r, warn_trip_r, ds_flag_r, 1'b0, 1'b0, ds_sel};
    assign rd_opt = {wdog_clk, 7'h00};

    // Unmapped offsets read zero
    wire [DATA_W-1:0]  rd_mux = sel_det ? rd_det :
                                sel_wrn ? rd_wrn :
                                sel_opt ? rd_opt :
                                sel_evt ? {5'h00, evt_status_r} :
                                sel_msk ? {5'h00, evt_mask_r} :
                                          RST_RDATA;

    // Detect comparator synchroniser; only the second stage feeds logic
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            det_meta_r <= 1'b0;
            det_sync_r <= 1'b0;
        end else begin
            det_meta_r <= UNDERVOLT_DETECT_IN;
            det_sync_r <= det_meta_r;
        end
    end

    // Warning comparator synchroniser; a supply already low at release sets the flag from the third edge
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            wrn_meta_r <= 1'b0;
            wrn_sync_r <= 1'b0;
        end else begin
            wrn_meta_r <= SUPPLY_WARNING_IN;
            wrn_sync_r <= wrn_meta_r;
        end
    end

    // Write-once controls; a write to the register consumes all of its write-once bits,
    // even when software meant to change only the other fields
    pmc_wonce_bit #(.RESET_VAL(RST_RST_EN)) u_rst_en (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_in     (wr_det),
        .data_in   (WDATA_IN[DET_RST_EN_BIT]),
        .value_out (rst_en)
    );

    pmc_wonce_bit #(.RESET_VAL(RST_STOP_EN)) u_stop_en (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_in     (wr_det),
        .data_in   (WDATA_IN[DET_STOP_EN_BIT]),
        .value_out (stop_en)
    );

    pmc_wonce_bit #(.RESET_VAL(RST_MASTER_EN)) u_master_en (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_in     (wr_det),
        .data_in   (WDATA_IN[DET_MASTER_EN_BIT]),
        .value_out (master_en)
    );

    pmc_wonce_bit #(.RESET_VAL(RST_DS_SEL)) u_ds_sel (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_in     (wr_wrn),
        .data_in   (WDATA_IN[WRN_DS_SEL_BIT]),
        .value_out (ds_sel)
    );

    pmc_wonce_bit #(.RESET_VAL(RST_WDOG_CLK)) u_wdog_clk (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (RST_N_IN),
        .wr_in     (wr_opt),
        .data_in   (WDATA_IN[OPT_WDOG_CLK_BIT]),
        .value_out (wdog_clk)
    );

    // Detect interrupt enable, plain read/write
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            irq_en_r <= RST_IRQ_EN;
        end else if (wr_det) begin
            irq_en_r <= WDATA_IN[DET_IRQ_EN_BIT];
        end
    end

    // Reference buffer enable, plain read/write
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            refbuf_en_r <= RST_REFBUF_EN;
        end else if (wr_det) begin
            refbuf_en_r <= WDATA_IN[DET_REFBUF_EN_BIT];
        end
    end

    // Event mask, same layout as the event status
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            evt_mask_r <= RST_EVT_MASK;
        end else if (wr_msk) begin
            evt_mask_r <= WDATA_IN[EVT_W-1:0];
        end
    end

    // Detect trip select survives every reset except power-on
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            if (POR_CAUSE_IN) begin
                det_trip_r <= RST_TRIP_SEL;
            end
        end else if (wr_wrn) begin
            det_trip_r <= WDATA_IN[WRN_DET_TRIP_BIT];
        end
    end

    // Warning trip select survives every reset except power-on
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            if (POR_CAUSE_IN) begin
                warn_trip_r <= RST_TRIP_SEL;
            end
        end else if (wr_wrn) begin
            warn_trip_r <= WDATA_IN[WRN_WARN_TRIP_BIT];
        end
    end

    // Detect flag
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            detect_flag_r <= 1'b0;
        end else begin
            detect_flag_r <= detect_flag_nxt;
        end
    end

    // Warning flag
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            warn_flag_r <= 1'b0;
        end else begin
            warn_flag_r <= warn_flag_nxt;
        end
    end

    // Deep-stop exit flag
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            ds_flag_r <= 1'b0;
        end else begin
            ds_flag_r <= ds_flag_nxt;
        end
    end

    // First cycle after release; the wake input is looked at only then
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            first_cycle_r <= 1'b1;
        end else begin
            first_cycle_r <= 1'b0;
        end
    end

    // Sticky event status
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            evt_status_r <= {EVT_W{1'b0}};
        end else begin
            evt_status_r <= evt_status_nxt;
        end
    end

    // Reset request held until the system reset removes it;
    // a level, so a slow reset controller cannot miss it
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            reset_req_r <= 1'b0;
        end else if (detect_flag_nxt && rst_en && master_en) begin
            reset_req_r <= 1'b1;
        end
    end

    // Read data, valid the cycle after the read strobe;
    // zero otherwise so a stale value never lingers on the bus
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            rdata_r <= RST_RDATA;
        end else if (RD_IN) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= RST_RDATA;
        end
    end

    // Read data and register-backed controls
    assign RDATA_OUT            = rdata_r;
    assign DETECT_TRIP_SEL_OUT  = det_trip_r;
    assign WARN_TRIP_SEL_OUT    = warn_trip_r;
    assign REF_BUF_EN_OUT       = refbuf_en_r;
    assign DEEP_STOP_SEL_OUT    = ds_sel;
    assign WDOG_CLK_SEL_OUT     = wdog_clk;

    // Detector state and requests
    assign UNDERVOLT_ACTIVE_OUT = det_live;
    assign UNDERVOLT_RESET_OUT  = reset_req_r;
    assign UNDERVOLT_IRQ_OUT    = irq_en_r && detect_flag_r;

    // Event interrupt, high while any unmasked event is pending
    assign EVT_IRQ_OUT          = |(evt_status_r & evt_mask_r);

endmodule : pmc_top

// [hdl/pmc_wonce_bit.sv]
`timescale 1ns/1ps

// Control bit that takes only the first write after each reset
module pmc_wonce_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Write port
    input  wire logic wr_in,
    input  wire logic data_in,
    // State
    output logic      value_out
);

    logic used_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            value_out <= RESET_VAL;
            used_r    <= 1'b0;
        end else if (wr_in && !used_r) begin
            value_out <= data_in;
            used_r    <= 1'b1;
        end
    end

endmodule : pmc_wonce_bit

// [tb/pmc_top_checker.sv]
`timescale 1ns/1ps

module pmc_top_checker
    import pmc_pkg::*;
(
    // Clock, reset and cause
    input wire logic                      REF_CLK_IN,
    input wire logic                      RST_N_IN,
    input wire logic                      POR_CAUSE_IN,
    // Register bus
    input wire logic [pmc_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [pmc_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic                      WR_IN,
    input wire logic                      RD_IN,
    input wire logic [pmc_pkg::DATA_W-1:0] RDATA_OUT,
    // Outputs under watch
    input wire logic                      DETECT_TRIP_SEL_OUT,
    input wire logic                      WARN_TRIP_SEL_OUT,
    input wire logic                      REF_BUF_EN_OUT,
    input wire logic                      DEEP_STOP_SEL_OUT,
    input wire logic                      WDOG_CLK_SEL_OUT,
    input wire logic                      UNDERVOLT_ACTIVE_OUT,
    input wire logic                      UNDERVOLT_RESET_OUT,
    input wire logic                      UNDERVOLT_IRQ_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    wire rd0 = RD_IN && ADDR_IN == OFS_DETECT_CTRL;
    wire rd1 = RD_IN && ADDR_IN == OFS_WARN_STOP_CTRL;
    wire rd2 = RD_IN && ADDR_IN == OFS_SYS_OPTIONS;
    wire wr0 = WR_IN && ADDR_IN == OFS_DETECT_CTRL;
    wire wr1 = WR_IN && ADDR_IN == OFS_WARN_STOP_CTRL;

    a_det_ack_zero: assert property (rd0 |=> RDATA_OUT[6] == 1'b0 && RDATA_OUT[1] == 1'b0)
        else $error("detect ack or reserved bit read as one");
    a_irq_follows: assert property (rd0 |=> (RDATA_OUT[7] & RDATA_OUT[5]) == $past(UNDERVOLT_IRQ_OUT))
        else $error("detect interrupt differs from flag and enable");
    a_refbuf_read: assert property (rd0 |=> RDATA_OUT[0] == $past(REF_BUF_EN_OUT))
        else $error("buffer enable differs from register");
    a_refbuf_write: assert property (wr0 |=> REF_BUF_EN_OUT == $past(WDATA_IN[0]))
        else $error("buffer enable not written");
    a_trip_write: assert property (wr1 |=> {DETECT_TRIP_SEL_OUT, WARN_TRIP_SEL_OUT} == $past(WDATA_IN[5:4]))
        else $error("trip selects not written");
    a_warn_reg_read: assert property (rd1 |=> RDATA_OUT[6] == 1'b0 && RDATA_OUT[2] == 1'b0
        && RDATA_OUT[5:4] == $past({DETECT_TRIP_SEL_OUT, WARN_TRIP_SEL_OUT})
        && RDATA_OUT[0] == $past(DEEP_STOP_SEL_OUT))
        else $error("warning register read mismatch");
    a_wdog_read: assert property (rd2 |=> RDATA_OUT == {$past(WDOG_CLK_SEL_OUT), 7'h00})
        else $error("options register read mismatch");
    a_trip_por: assert property (disable iff (1'b0) !RST_N_IN && POR_CAUSE_IN |=>
        !DETECT_TRIP_SEL_OUT && !WARN_TRIP_SEL_OUT) else $error("trip selects not cleared");
    a_trip_keep: assert property (disable iff (1'b0) !RST_N_IN && !POR_CAUSE_IN |=>
        $stable(DETECT_TRIP_SEL_OUT) && $stable(WARN_TRIP_SEL_OUT)) else $error("trip selects lost");
    a_reset_sticky: assert property (UNDERVOLT_RESET_OUT |=> UNDERVOLT_RESET_OUT)
        else $error("reset request dropped");
    a_active_boot: assert property ($rose(RST_N_IN) |-> UNDERVOLT_ACTIVE_OUT)
        else $error("detector inactive after reset");
endmodule : pmc_top_checker

bind pmc_top pmc_top_checker i_chk (.REF_CLK_IN, .RST_N_IN, .POR_CAUSE_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
    .RD_IN, .RDATA_OUT, .DETECT_TRIP_SEL_OUT, .WARN_TRIP_SEL_OUT, .REF_BUF_EN_OUT, .DEEP_STOP_SEL_OUT,
    .WDOG_CLK_SEL_OUT, .UNDERVOLT_ACTIVE_OUT, .UNDERVOLT_RESET_OUT, .UNDERVOLT_IRQ_OUT);

// [tb/test_pmc_top.sv]
`timescale 1ns/1ps

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module test_pmc_top;
    import pmc_pkg::*;
    logic              clk = 1'b0, rst_n = 1'b0, por = 1'b1, dswake = 1'b0;
    logic              stop = 1'b0, uvd = 1'b0, warn = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, exp_v, msk_v, r;
    logic [DATA_W-1:0] exp_q[$], msk_q[$];
    logic              dtrip, wtrip, refbuf, dssel, wdog, active, uvrst, uvirq, evirq;
    logic [31:0]       seed = 32'd91987;
    int                err_count = 0, check_count = 0;

    always #20 clk = ~clk;

    pmc_top i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .POR_CAUSE_IN(por), .DEEP_STOP_WAKE_IN(dswake),
        .STOP_MODE_IN(stop), .UNDERVOLT_DETECT_IN(uvd), .SUPPLY_WARNING_IN(warn), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DETECT_TRIP_SEL_OUT(dtrip),
        .WARN_TRIP_SEL_OUT(wtrip), .REF_BUF_EN_OUT(refbuf), .DEEP_STOP_SEL_OUT(dssel),
        .WDOG_CLK_SEL_OUT(wdog), .UNDERVOLT_ACTIVE_OUT(active), .UNDERVOLT_RESET_OUT(uvrst),
        .UNDERVOLT_IRQ_OUT(uvirq), .EVT_IRQ_OUT(evirq));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // Read data stands in the cycle after the read strobe
    always @(posedge clk) begin
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            msk_v = msk_q.pop_front();
            `CHK(rdata & msk_v, exp_v)
        end
        rd_d <= rd && rst_n;
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic do_reset(input logic p, input logic w);
        @(posedge clk);
        rst_n <= 1'b0;
        por <= p;
        dswake <= w;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        dswake <= 1'b0;
    endtask : do_reset

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        $display("[ERR] %0t run limit reached", $time);
        err_count++;
        finish_test();
    end

    initial begin
        do_reset(1'b1, 1'b0);
        rd_chk(OFS_DETECT_CTRL, 8'h1c, 8'hff);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h00, 8'hff);
        rd_chk(OFS_SYS_OPTIONS, 8'h00, 8'hff);
        rd_chk(3'h5, 8'h00, 8'hff);
        $display("reset values done");
        r = rnd();
        wr_reg(OFS_DETECT_CTRL, 8'h2c | r & 8'h01);
        wr_reg(OFS_DETECT_CTRL, 8'h30 | ~r & 8'h01);
        rd_chk(OFS_DETECT_CTRL, 8'h2c | ~r & 8'h01, 8'hff);
        step(1);
        `CHK(refbuf, ~r[0])
        $display("write once done");
        @(posedge clk) uvd <= 1'b1;
        step(4);
        `CHK({uvirq, uvrst}, 2'b10)
        @(posedge clk) uvd <= 1'b0;
        step(4);
        rd_chk(OFS_DETECT_CTRL, 8'h80, 8'h80);
        wr_reg(OFS_DETECT_CTRL, 8'h60 | r & 8'h01);
        rd_chk(OFS_DETECT_CTRL, 8'h2c | r & 8'h01, 8'hff);
        step(1);
        `CHK(uvirq, 1'b0)
        $display("detect flag done");
        @(posedge clk) warn <= 1'b1;
        step(4);
        wr_reg(OFS_WARN_STOP_CTRL, 8'h41 | r & 8'h30);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h81 | r & 8'h30, 8'hff);
        step(1);
        `CHK({dtrip, wtrip, dssel}, {r[5], r[4], 1'b1})
        @(posedge clk) warn <= 1'b0;
        step(4);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h80, 8'h80);
        wr_reg(OFS_WARN_STOP_CTRL, 8'h40 | ~r & 8'h30);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h01 | ~r & 8'h30, 8'hff);
        wr_reg(OFS_SYS_OPTIONS, 8'h80);
        wr_reg(OFS_SYS_OPTIONS, 8'h00);
        rd_chk(OFS_SYS_OPTIONS, 8'h80, 8'hff);
        `CHK(wdog, 1'b1)
        rd_chk(OFS_EVT_STATUS, 8'h03, 8'hff);
        wr_reg(OFS_EVT_MASK, 8'h02);
        step(1);
        `CHK(evirq, 1'b1)
        wr_reg(OFS_EVT_STATUS, 8'h02);
        step(1);
        `CHK(evirq, 1'b0)
        $display("warning and events done");
        do_reset(1'b0, 1'b1);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h08 | ~r & 8'h30, 8'hff);
        wr_reg(OFS_WARN_STOP_CTRL, 8'h04 | ~r & 8'h30);
        rd_chk(OFS_WARN_STOP_CTRL, ~r & 8'h30, 8'hff);
        wr_reg(OFS_DETECT_CTRL, 8'h14);
        @(posedge clk) stop <= 1'b1;
        step(1);
        `CHK(active, 1'b0)
        @(posedge clk) uvd <= 1'b1;
        step(4);
        rd_chk(OFS_DETECT_CTRL, 8'h14, 8'hff);
        @(posedge clk) stop <= 1'b0;
        step(4);
        `CHK(uvrst, 1'b1)
        rd_chk(OFS_DETECT_CTRL, 8'h94, 8'hff);
        $display("second reset done");
        @(posedge clk) warn <= 1'b1;
        uvd <= 1'b0;
        do_reset(1'b1, 1'b0);
        step(2);
        rd_chk(OFS_WARN_STOP_CTRL, 8'h80, 8'hff);
        wr_reg(OFS_DETECT_CTRL, 8'h00);
        @(posedge clk) uvd <= 1'b1;
        step(4);
        rd_chk(OFS_DETECT_CTRL, 8'h00, 8'hff);
        `CHK({active, uvrst}, 2'b00)
        $display("power-on reset done");
        step(2);
        finish_test();
    end
endmodule : test_pmc_top
